/* File: common/rcl_pkg.sv */
// Purpose: shared constants and carriers for channel lock/adapt control
// Assumes: byte-wide register port, 20 MHz core clock
// Notes: offsets are byte addresses within one channel's map
package rcl_pkg;
   // Register offsets
   localparam logic [7:0] REG_DEM = 8'h15;
   localparam logic [7:0] REG_TRIG = 8'h24;
   localparam logic [7:0] REG_VOD = 8'h2d;
   localparam logic [7:0] REG_START = 8'h2f;
   localparam logic [7:0] REG_ADAPT = 8'h31;
   localparam logic [7:0] REG_REFC = 8'h36;
   localparam logic [7:0] REG_THR = 8'h6a;
   localparam logic [7:0] REG_STAT = 8'h70;
   // Field positions
   localparam int ADAPT_LSB = 5;
   localparam int START_BIT = 0;
   localparam int REFM_LSB = 4;
   localparam int RANGE_BIT = 6;
   // Reset values
   localparam logic [7:0] RST_ADAPT = 8'h20;
   localparam logic [7:0] RST_THR = 8'h44;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // Codes
   localparam logic [1:0] ADAPT_NONE = 2'b00;
   localparam logic [1:0] ADAPT_OPT = 2'b01;
   localparam logic [1:0] REFM_ON = 2'b11;
   localparam logic [3:0] COARSE_MAX = 4'hf;
   // Frequency window: divided reference ticks and vco tick band
   localparam logic [7:0] REF_WIN_LAST = 8'h3f;
   localparam logic [7:0] VCO_LO = 8'h3e;
   localparam logic [7:0] VCO_HI = 8'h42;
   // Swing in units of 10 mV
   localparam logic [7:0] VOD_BASE = 8'h3c;
   localparam logic [7:0] VOD_STEP = 8'h0a;
   // De-emphasis magnitude in tenths of dB, index is level code
   localparam logic [7:0][7:0] DEM_HI = {8'h38, 8'h2d, 8'h27, 8'h21,
      8'h1c, 8'h14, 8'h09, 8'h00};
   localparam logic [7:0][7:0] DEM_LO = {8'h78, 8'h5a, 8'h4b, 8'h3c,
      8'h32, 8'h23, 8'h0f, 8'h00};

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rcl_req_t;

   typedef struct packed {
      logic [7:0] horizontal_eye_opening;
      logic [7:0] vertical_eye_opening;
   } rcl_eye_t;

   typedef struct packed {
      logic [2:0] vod_code;
      logic [7:0] vod_10mv;
      logic [7:0] dem_tenth_db;
   } rcl_drv_t;

   typedef enum logic [3:0] {
      ST_CAL = 4'b0001,
      ST_ACQ = 4'b0010,
      ST_QUAL = 4'b0100,
      ST_LOCK = 4'b1000
   } rcl_state_t;
endpackage

/* File: design/rcl_chan_ctrl.sv */
// Purpose: per-channel lock, adaptation and driver setting control
// Assumes: eye and cdr inputs on clk; divided clocks arrive as pins
// Notes: frequency checks run only with reference mode enabled
`timescale 1ns/1ns

module rcl_chan_ctrl
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire rcl_pkg::rcl_req_t req,
   input wire rcl_pkg::rcl_eye_t eye,
   input wire logic cdr_locked_in,
   input wire logic ref_div_in,
   input wire logic vco_div_in,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output rcl_pkg::rcl_drv_t drv,
   output logic [3:0] vco_coarse,
   output logic [1:0] ref_mode,
   output logic adapt_enable,
   output logic adapt_start,
   output logic lock_out,
   output logic lock_lost,
   output logic cal_busy
);
   import rcl_pkg::*;

   logic [7:0] dem, trig, vod, start, adapt, refc, thr;
   logic [7:0] next_dem, next_trig, next_vod, next_start;
   logic [7:0] next_adapt, next_refc, next_thr;
   logic [7:0] next_rd_data;
   logic next_rd_valid;
   logic [1:0] ref_s, vco_s;
   logic ref_d, vco_d, start_prev;
   logic [7:0] ref_cnt, vco_cnt, next_ref_cnt, next_vco_cnt;
   rcl_state_t st, next_st;
   logic [3:0] next_coarse;
   logic next_start_p, next_lost;
   rcl_drv_t next_drv;
   logic ref_rise, vco_rise, win_end, win_clr, freq_ok;
   logic ref_on, adapt_on, eye_good, eye_bad, sw_trig;
   logic rst_q;

   // Derived conditions
   assign ref_on = refc[REFM_LSB +: 2] == REFM_ON;
   assign adapt_on = adapt[ADAPT_LSB +: 2] == ADAPT_OPT;
   assign eye_good = eye.horizontal_eye_opening > {thr[7:4], 4'h0}
      && eye.vertical_eye_opening > {thr[3:0], 4'h0};
   assign eye_bad = eye.horizontal_eye_opening < {thr[7:4], 4'h0}
      || eye.vertical_eye_opening < {thr[3:0], 4'h0};
   assign sw_trig = start_prev && !start[START_BIT];
   assign ref_rise = ref_s[1] && !ref_d;
   assign vco_rise = vco_s[1] && !vco_d;
   assign win_end = ref_rise && ref_cnt == REF_WIN_LAST;
   assign freq_ok = vco_cnt >= VCO_LO && vco_cnt <= VCO_HI;
   assign win_clr = next_st != st;

   // Register writes and read data
   always_comb
   begin
      next_dem = dem;
      next_trig = trig;
      next_vod = vod;
      next_start = start;
      next_adapt = adapt;
      next_refc = refc;
      next_thr = thr;
      next_rd_valid = req.rd;
      next_rd_data = 8'h00;
      if (req.wr)
      begin
         case (req.addr)
            REG_DEM: next_dem = req.wdata;
            REG_TRIG: next_trig = req.wdata;
            REG_VOD: next_vod = req.wdata;
            REG_START: next_start = req.wdata;
            REG_ADAPT:
            begin
               next_adapt = req.wdata;
               // Reserved codes leave the old mode in place
               if (req.wdata[ADAPT_LSB + 1])
                  next_adapt[ADAPT_LSB +: 2] = adapt[ADAPT_LSB +: 2];
            end
            REG_REFC: next_refc = req.wdata;
            REG_THR: next_thr = req.wdata;
            default: next_thr = thr;
         endcase
      end
      if (req.rd)
      begin
         case (req.addr)
            REG_DEM: next_rd_data = dem;
            REG_TRIG: next_rd_data = trig;
            REG_VOD: next_rd_data = vod;
            REG_START: next_rd_data = start;
            REG_ADAPT: next_rd_data = adapt;
            REG_REFC: next_rd_data = refc;
            REG_THR: next_rd_data = thr;
            REG_STAT: next_rd_data = {st, vco_coarse};
            default: next_rd_data = 8'h00;
         endcase
      end
   end

   // Register storage
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dem <= RST_ZERO;
         trig <= RST_ZERO;
         vod <= RST_ZERO;
         start <= RST_ZERO;
         adapt <= RST_ADAPT;
         refc <= RST_ZERO;
         thr <= RST_THR;
         rd_data <= RST_ZERO;
         rd_valid <= 1'b0;
         start_prev <= 1'b0;
      end
      else
      begin
         dem <= next_dem;
         trig <= next_trig;
         vod <= next_vod;
         start <= next_start;
         adapt <= next_adapt;
         refc <= next_refc;
         thr <= next_thr;
         rd_data <= next_rd_data;
         rd_valid <= next_rd_valid;
         start_prev <= start[START_BIT];
      end
   end

   // Pin synchronisers for the divided reference and vco clocks
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ref_s <= 2'b00;
         vco_s <= 2'b00;
         ref_d <= 1'b0;
         vco_d <= 1'b0;
         rst_q <= 1'b1;
      end
      else
      begin
         ref_s <= {ref_s[0], ref_div_in};
         vco_s <= {vco_s[0], vco_div_in};
         ref_d <= ref_s[1];
         vco_d <= vco_s[1];
         rst_q <= 1'b0;
      end
   end

   // Frequency window: count vco ticks over a fixed reference span
   always_comb
   begin
      next_ref_cnt = ref_cnt + {7'h00, ref_rise};
      next_vco_cnt = vco_cnt;
      if (vco_rise && vco_cnt != 8'hff)
         next_vco_cnt = vco_cnt + 8'h01;
      if (win_clr || win_end)
      begin
         next_ref_cnt = 8'h00;
         next_vco_cnt = 8'h00;
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ref_cnt <= 8'h00;
         vco_cnt <= 8'h00;
      end
      else
      begin
         ref_cnt <= next_ref_cnt;
         vco_cnt <= next_vco_cnt;
      end
   end

   // Lock state machine
   always_comb
   begin
      next_st = st;
      next_coarse = vco_coarse;
      next_start_p = 1'b0;
      next_lost = 1'b0;
      unique case (st)
         ST_CAL:
            // Step coarse tuning until the vco lands in band or coarse tuning reaches COARSE_MAX
            if (ref_on && win_end)
            begin
               if (freq_ok || vco_coarse == COARSE_MAX)
               begin
                  next_st = ST_ACQ;
                  next_start_p = adapt_on;
               end
               else
                  next_coarse = vco_coarse + 4'h1;
            end
         ST_ACQ:
            if (cdr_locked_in && eye_good)
               next_st = ST_QUAL;
         ST_QUAL:
            if (!cdr_locked_in || !eye_good)
            begin
               next_st = ST_ACQ;
               next_start_p = adapt_on;
            end
            else if (!ref_on)
               next_st = ST_LOCK;
            else if (win_end)
            begin
               next_st = freq_ok ? ST_LOCK : ST_ACQ;
               next_start_p = adapt_on && !freq_ok;
            end
         ST_LOCK:
            if (eye_bad || !cdr_locked_in
               || (ref_on && win_end && !freq_ok))
            begin
               next_st = ST_ACQ;
               next_start_p = adapt_on;
               next_lost = 1'b1;
            end
      endcase
      if (sw_trig && st != ST_CAL)
      begin
         next_st = ST_ACQ;
         next_start_p = adapt_on;
      end
   end

   // Drive settings lookup
   always_comb
   begin
      next_drv.vod_code = vod[2:0];
      next_drv.vod_10mv = 8'(VOD_BASE + VOD_STEP * {5'h00, vod[2:0]});
      next_drv.dem_tenth_db = dem[RANGE_BIT] ? DEM_HI[dem[2:0]]
         : DEM_LO[dem[2:0]];
   end

   // State and output registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         st <= ST_CAL;
         vco_coarse <= 4'h0;
         adapt_start <= 1'b0;
         lock_lost <= 1'b0;
         lock_out <= 1'b0;
         cal_busy <= 1'b1;
         ref_mode <= 2'b00;
         adapt_enable <= 1'b0;
         drv <= '0;
      end
      else
      begin
         st <= next_st;
         vco_coarse <= next_coarse;
         adapt_start <= next_start_p;
         lock_lost <= next_lost;
         lock_out <= next_st == ST_LOCK;
         cal_busy <= next_st == ST_CAL;
         ref_mode <= refc[REFM_LSB +: 2];
         adapt_enable <= adapt_on;
         drv <= next_drv;
      end
   end

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence s_rst_rel;
      rst_q && !sys_rst;
   endsequence

   sequence s_eye_drop;
      st == ST_LOCK && eye_bad;
   endsequence

   a_adapt_default:
      assert property (s_rst_rel |-> adapt[ADAPT_LSB +: 2] == ADAPT_OPT)
      else $error("adapt mode not 01 after reset");
   a_lock_eye_ok:
      assert property ($rose(lock_out) |-> $past(eye_good))
      else $error("lock without both eye openings");
   a_eye_drop_loss:
      assert property (s_eye_drop |=> !lock_out && lock_lost)
      else $error("lock held with closed eye");
   a_auto_restart:
      assert property ($fell(lock_out) |->
         st == ST_ACQ && adapt_start == adapt_enable)
      else $error("no restart after unlock");
   a_sw_trigger:
      assert property (sw_trig && st != ST_CAL |=>
         st == ST_ACQ && adapt_start == adapt_enable)
      else $error("software trigger ignored");
   a_cal_reset:
      assert property (s_rst_rel |-> st == ST_CAL ##1 cal_busy)
      else $error("no calibration after reset");
   a_coarse_hold:
      assert property (st != ST_CAL |=> $stable(vco_coarse))
      else $error("coarse tuning moved outside calibration");
   a_drift_report:
      assert property (st == ST_LOCK && ref_on && win_end && !freq_ok
         |=> lock_lost && !lock_out)
      else $error("drift not reported");
   a_false_lock:
      assert property (st == ST_QUAL && ref_on && win_end && !freq_ok
         |=> st == ST_ACQ)
      else $error("false lock accepted");
   a_swing_map:
      assert property (vod[2:0] == 3'h7 |=> drv.vod_10mv == 8'h82)
      else $error("swing code 7 not 1.3 V");
   a_dem_zero:
      assert property (dem[2:0] == 3'h0 |=> drv.dem_tenth_db == 8'h00)
      else $error("level 000 not 0 dB");
   a_dem_range_hi:
      assert property (dem[RANGE_BIT] && dem[2:0] == 3'h1
         |=> drv.dem_tenth_db == 8'h09)
      else $error("range one level 1 not 0.9 dB");
   a_dem_range_lo:
      assert property (!dem[RANGE_BIT] && dem[2:0] == 3'h7
         |=> drv.dem_tenth_db == 8'h78)
      else $error("range zero level 7 not 12 dB");
   a_mode_reserved:
      assert property (req.wr && req.addr == REG_ADAPT
         && req.wdata[ADAPT_LSB + 1] |=> $stable(adapt[ADAPT_LSB +: 2]))
      else $error("reserved adapt code stored");
endmodule // rcl_chan_ctrl

/* File: bench/rcl_far_model.sv */
// Purpose: divided reference and vco pins seen by the channel
// Assumes: reference and in-band vco both divided to 400 ns
// Notes: fast pulls the vco out of band, like a spur lock
`timescale 1ns/1ns
module rcl_far_model
(
   input wire logic fast,
   output logic ref_div,
   output logic vco_div
);
   // Reference never stops, even between tests
   initial ref_div = 1'b0;
   always #200 ref_div = ~ref_div;
   // Vco with its own phase; fast gives about 85 ticks a window
   initial vco_div = 1'b0;
   always
   begin
      #(fast ? 150 : 200);
      vco_div = ~vco_div;
   end
endmodule // rcl_far_model

/* File: bench/tb_rcl_chan_ctrl.sv */
// Purpose: register and lock sequence tests of the channel control
// Assumes: 50 ns clock, 512 clocks per frequency window
// Notes: eye thresholds left at reset value, 0x40 on both axes
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
n_mismatch++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb_rcl_chan_ctrl;
   import rcl_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   rcl_req_t req = '0;
   rcl_eye_t eye = '0;
   logic cdr_locked_in = 1'b0;
   logic fast = 1'b1;
   logic ref_div, vco_div, rd_valid, adapt_enable, adapt_start;
   logic lock_out, lock_lost, cal_busy;
   logic [7:0] rd_data;
   rcl_drv_t drv;
   logic [3:0] vco_coarse;
   logic [1:0] ref_mode;
   int n_mismatch = 0;
   int cmp_count = 0;
   int n_start = 0;
   int s;
   logic [7:0] hi [8] = '{8'h00, 8'h09, 8'h14, 8'h1c, 8'h21, 8'h27,
      8'h2d, 8'h38};
   logic [7:0] lo [8] = '{8'h00, 8'h0f, 8'h23, 8'h32, 8'h3c, 8'h4b,
      8'h5a, 8'h78};

   always #25 clk = ~clk;
   always @(posedge clk) if (adapt_start === 1'b1) n_start++;

   rcl_chan_ctrl u_rcl_chan_ctrl (.clk(clk), .sys_rst(sys_rst),
      .req(req), .eye(eye), .cdr_locked_in(cdr_locked_in),
      .ref_div_in(ref_div), .vco_div_in(vco_div), .rd_data(rd_data),
      .rd_valid(rd_valid), .drv(drv), .vco_coarse(vco_coarse),
      .ref_mode(ref_mode), .adapt_enable(adapt_enable),
      .adapt_start(adapt_start), .lock_out(lock_out),
      .lock_lost(lock_lost), .cal_busy(cal_busy));
   rcl_far_model u_rcl_far_model (.fast(fast), .ref_div(ref_div),
      .vco_div(vco_div));

   task automatic finish_test();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // One-cycle write strobe
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask

   // Read strobe, data checked in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk);
      req.rd <= 1'b0;
      #1;
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, e)
   endtask

   // Bounded wait: 0 cal done, 1 locked, 2 lock lost, 3 start pulse
   task automatic wait_on(input int sel, input int lim);
      repeat (lim)
      begin
         @(posedge clk);
         #1;
         if ((sel == 0 && cal_busy === 1'b0) ||
            (sel == 1 && lock_out === 1'b1) ||
            (sel == 2 && lock_lost === 1'b1) ||
            (sel == 3 && adapt_start === 1'b1))
            return;
      end
      `CHK(sel, -1)
   endtask

   initial
   begin
      #2_000_000;
      n_mismatch++;
      finish_test();
   end

   initial
   begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHK(cal_busy, 1'b1)
      rd(REG_ADAPT, 8'h20);
      rd(REG_THR, 8'h44);
      rd(REG_STAT, 8'h10);
      `CHK(adapt_enable, 1'b1)
      wr(8'h55, 8'hff);
      rd(8'h55, 8'h00);
      wr(REG_STAT, 8'hff);
      rd(REG_STAT, 8'h10);
      wr(REG_TRIG, 8'ha5);
      rd(REG_TRIG, 8'ha5);
      for (int n = 0; n < 8; n++)
      begin
         wr(REG_VOD, 8'(n));
         @(posedge clk);
         #1;
         `CHK(drv.vod_10mv, 8'(60 + 10 * n))
         `CHK(drv.vod_code, 3'(n))
      end
      for (int r = 0; r < 2; r++)
         for (int l = 0; l < 8; l++)
         begin
            wr(REG_DEM, 8'((r << 6) | l));
            @(posedge clk);
            #1;
            `CHK(drv.dem_tenth_db, (r == 1) ? hi[l] : lo[l])
         end
      wr(REG_ADAPT, 8'h40);
      rd(REG_ADAPT, 8'h20);
      wr(REG_ADAPT, 8'h60);
      rd(REG_ADAPT, 8'h20);
      // Coarse sweep with vco out of band ends at the top setting
      wr(REG_REFC, 8'h30);
      wait_on(0, 10000);
      `CHK(vco_coarse, COARSE_MAX)
      `CHK(ref_mode, REFM_ON)
      // Drive the channel inputs on a rising edge again
      @(posedge clk);
      eye <= '{horizontal_eye_opening: 8'h50, vertical_eye_opening: 8'h40};
      cdr_locked_in <= 1'b1;
      fast <= 1'b0;
      repeat (1200) @(posedge clk);
      `CHK(lock_out, 1'b0)
      rd(REG_STAT, 8'h2f);
      @(posedge clk);
      eye.vertical_eye_opening <= 8'h41;
      wait_on(1, 1500);
      @(posedge clk);
      eye.vertical_eye_opening <= 8'h40;
      repeat (20) @(posedge clk);
      `CHK(lock_out, 1'b1)
      eye.vertical_eye_opening <= 8'h3f;
      wait_on(2, 4);
      `CHK(adapt_start, 1'b1)
      `CHK(lock_out, 1'b0)
      @(posedge clk);
      eye.vertical_eye_opening <= 8'h41;
      wait_on(1, 1500);
      fast <= 1'b1;
      wait_on(2, 1200);
      s = n_start;
      repeat (1200) @(posedge clk);
      // The lost-lock pulse alone counts one; a spur restart adds more
      `CHK(n_start > s + 1, 1'b1)
      `CHK(lock_out, 1'b0)
      fast <= 1'b0;
      wait_on(1, 1500);
      wr(REG_START, 8'h01);
      wr(REG_START, 8'h00);
      wait_on(3, 4);
      `CHK(lock_out, 1'b0)
      wr(REG_ADAPT, 8'h00);
      @(posedge clk);
      #1;
      `CHK(adapt_enable, 1'b0)
      s = n_start;
      wr(REG_START, 8'h01);
      wr(REG_START, 8'h00);
      repeat (6) @(posedge clk);
      `CHK(n_start, s)
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      `CHK(cal_busy, 1'b1)
      rd(REG_ADAPT, 8'h20);
      finish_test();
   end
endmodule // tb_rcl_chan_ctrl
